// ### emt_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Address stays stable for setup-field cycles (0 to 3) before a strobe is asserted.
// - A read or write strobe lasts the width field plus one cycles, 1 to 16.
// - Address and control stay held for hold-field cycles (0 to 3) after the strobe ends.
// - The timing register sits at 0xAF on page 0x0 with setup 7:6, width 5:2, hold 1:0.
// - In modes 01, 10 and 11 a wide-address move is a latch phase then a strobe phase.
// - In modes 01 and 11 a narrow-address move leaves the page value off the upper lines.
// - In mode 10 a narrow-address move puts the page value on the upper address lines.
// - Write data is driven from one to nineteen cycles before the write strobe ends.
// - Write data stays driven for the hold setting, zero to three cycles, after the strobe.
// - The mode field picks internal only, split without bank, split with bank or external.
// - The latch strobe stays high and then low for the latch field plus one cycles each.
// - In mode 10 narrow moves take the upper address byte from the page register; its top bits read 0.
module emt_ctrl #(
	parameter int DEPTH = emt_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_wide,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic [7:0] addr_hi,
	output logic [7:0] ad_out,
	output logic ad_oe,
	input wire logic [7:0] ad_in,
	output logic ale,
	output logic rd_n,
	output logic wr_n
);
	emt_stream_if #(.W(emt_pkg::REQ_W)) in_if ();
	emt_stream_if #(.W(emt_pkg::REQ_W)) out_if ();

	emt_fifo #(.W(emt_pkg::REQ_W), .D(DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.wr_side(in_if.snk),
		.rd_side(out_if.src)
	);

	assign in_if.valid = req_valid;
	assign in_if.data = {req_write, req_wide, req_addr, req_wdata};
	assign req_ready = in_if.ready;

	// Register file
	logic [7:0] timing_q, timing_d, cfg_q, cfg_d, page_q, page_d, rdata_q, rdata_d;
	logic sel_page;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] r);
		hit = (pg == emt_pkg::SFR_PAGE_EMT) && (a == r);
	endfunction : hit

	assign sel_page = hit(sfr_addr, sfr_page, emt_pkg::ADDR_PAGE_CTL);

	always_comb begin
		timing_d = timing_q;
		cfg_d = cfg_q;
		page_d = page_q;
		rdata_d = rdata_q;
		if (sfr_wr && hit(sfr_addr, sfr_page, emt_pkg::ADDR_TIMING)) begin
			timing_d = sfr_wdata;
		end
		if (sfr_wr && hit(sfr_addr, sfr_page, emt_pkg::ADDR_BUS_CFG)) begin
			cfg_d = sfr_wdata & emt_pkg::CFG_MASK;
		end
		if (sfr_wr && sel_page) begin
			page_d = sfr_wdata & emt_pkg::PAGE_MASK;
		end
		if (sfr_rd) begin
			if (hit(sfr_addr, sfr_page, emt_pkg::ADDR_TIMING)) begin
				rdata_d = timing_q;
			end else if (hit(sfr_addr, sfr_page, emt_pkg::ADDR_BUS_CFG)) begin
				rdata_d = cfg_q;
			end else if (sel_page) begin
				rdata_d = page_q;
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timing_q <= emt_pkg::RST_TIMING;
			cfg_q <= emt_pkg::RST_BUS_CFG;
			page_q <= emt_pkg::RST_PAGE_CTL;
			rdata_q <= 8'h00;
		end else begin
			timing_q <= timing_d;
			cfg_q <= cfg_d;
			page_q <= page_d;
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;

	// Field decode
	logic [1:0] f_setup, f_hold, f_latch;
	logic [3:0] f_width;
	emt_pkg::emt_mode_t mode;

	assign f_setup = timing_q[emt_pkg::SETUP_LSB +: 2];
	assign f_width = timing_q[emt_pkg::WIDTH_LSB +: 4];
	assign f_hold = timing_q[emt_pkg::HOLD_LSB +: 2];
	assign f_latch = cfg_q[emt_pkg::LATCH_LSB +: 2];
	assign mode = emt_pkg::emt_mode_t'(cfg_q[emt_pkg::MODE_LSB +: 2]);

	// Bus cycle sequencer
	emt_pkg::emt_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic cw_q, cw_d;
	logic [7:0] c_lo_q, c_lo_d, c_dat_q, c_dat_d;
	logic [7:0] hi_q, hi_d, ado_q, ado_d, rsp_dat_q, rsp_dat_d;
	logic oe_q, oe_d, ale_q, ale_d, rdn_q, rdn_d, wrn_q, wrn_d, rsp_q, rsp_d;
	logic last;

	assign last = (cnt_q == 4'h0);
	assign out_if.ready = (st_q == emt_pkg::ST_IDLE);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q - 4'h1;
		cw_d = cw_q;
		c_lo_d = c_lo_q;
		c_dat_d = c_dat_q;
		hi_d = hi_q;
		rsp_d = 1'b0;
		rsp_dat_d = rsp_dat_q;
		unique case (st_q)
			emt_pkg::ST_IDLE: begin
				cnt_d = cnt_q;
				if (out_if.valid) begin
					if (mode == emt_pkg::MODE_INTERNAL) begin
						// No external bus: complete at once, reads return zero
						rsp_d = 1'b1;
						rsp_dat_d = 8'h00;
					end else begin
						cw_d = out_if.data[25];
						c_lo_d = out_if.data[15:8];
						c_dat_d = out_if.data[7:0];
						if (out_if.data[24]) begin
							hi_d = out_if.data[23:16];
						end else if (mode == emt_pkg::MODE_SPLIT_BANK) begin
							hi_d = page_q;
						end
						// Other modes keep the upper lines unchanged for narrow moves
						st_d = emt_pkg::ST_ALE_HIGH;
						cnt_d = {2'b00, f_latch};
					end
				end
			end
			emt_pkg::ST_ALE_HIGH: begin
				if (last) begin
					st_d = emt_pkg::ST_ALE_LOW;
					cnt_d = {2'b00, f_latch};
				end
			end
			emt_pkg::ST_ALE_LOW: begin
				if (last && f_setup != 2'b00) begin
					st_d = emt_pkg::ST_SETUP;
					cnt_d = {2'b00, f_setup - 2'b01};
				end else if (last) begin
					st_d = emt_pkg::ST_STROBE;
					cnt_d = f_width;
				end
			end
			emt_pkg::ST_SETUP: begin
				if (last) begin
					st_d = emt_pkg::ST_STROBE;
					cnt_d = f_width;
				end
			end
			emt_pkg::ST_STROBE: begin
				if (last) begin
					rsp_d = 1'b1;
					rsp_dat_d = cw_q ? 8'h00 : ad_in;
					if (f_hold != 2'b00) begin
						st_d = emt_pkg::ST_HOLD;
						cnt_d = {2'b00, f_hold - 2'b01};
					end else begin
						st_d = emt_pkg::ST_IDLE;
					end
				end
			end
			emt_pkg::ST_HOLD: begin
				if (last) begin
					st_d = emt_pkg::ST_IDLE;
				end
			end
			default: begin
				st_d = emt_pkg::ST_IDLE;
			end
		endcase
		// Pin values follow the phase being entered
		ale_d = (st_d == emt_pkg::ST_ALE_HIGH);
		rdn_d = !(st_d == emt_pkg::ST_STROBE && !cw_d);
		wrn_d = !(st_d == emt_pkg::ST_STROBE && cw_d);
		if (st_d == emt_pkg::ST_ALE_HIGH || st_d == emt_pkg::ST_ALE_LOW) begin
			oe_d = 1'b1;
			ado_d = c_lo_d;
		end else if (st_d != emt_pkg::ST_IDLE && cw_d) begin
			oe_d = 1'b1;
			ado_d = c_dat_d;
		end else begin
			oe_d = 1'b0;
			ado_d = ado_q;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= emt_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			cw_q <= 1'b0;
			c_lo_q <= 8'h00;
			c_dat_q <= 8'h00;
			hi_q <= 8'h00;
			ado_q <= 8'h00;
			oe_q <= 1'b0;
			ale_q <= 1'b0;
			rdn_q <= 1'b1;
			wrn_q <= 1'b1;
			rsp_q <= 1'b0;
			rsp_dat_q <= 8'h00;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			cw_q <= cw_d;
			c_lo_q <= c_lo_d;
			c_dat_q <= c_dat_d;
			hi_q <= hi_d;
			ado_q <= ado_d;
			oe_q <= oe_d;
			ale_q <= ale_d;
			rdn_q <= rdn_d;
			wrn_q <= wrn_d;
			rsp_q <= rsp_d;
			rsp_dat_q <= rsp_dat_d;
		end
	end

	assign addr_hi = hi_q;
	assign ad_out = ado_q;
	assign ad_oe = oe_q;
	assign ale = ale_q;
	assign rd_n = rdn_q;
	assign wr_n = wrn_q;
	assign rsp_valid = rsp_q;
	assign rsp_rdata = rsp_dat_q;
endmodule : emt_ctrl
`default_nettype wire

// ### emt_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module emt_chk (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic ad_oe,
	input wire logic [7:0] ad_out,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n
);
	logic [7:0] tim_q, cfg_q;
	logic [4:0] lo_q, su_q, al_q, hd_q;
	logic ws_q;
	wire logic sel = sfr_wr && sfr_page == emt_pkg::SFR_PAGE_EMT;
	wire logic st = rd_n && wr_n;
	// Shadow registers and phase counters
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tim_q <= emt_pkg::RST_TIMING;
			cfg_q <= emt_pkg::RST_BUS_CFG;
			{lo_q, su_q, al_q, hd_q, ws_q} <= '0;
		end else begin
			if (sel && sfr_addr == emt_pkg::ADDR_TIMING)
				tim_q <= sfr_wdata;
			if (sel && sfr_addr == emt_pkg::ADDR_BUS_CFG)
				cfg_q <= sfr_wdata;
			lo_q <= st ? 5'h00 : lo_q + 5'h01;
			su_q <= ale ? 5'h00 : st ? su_q + 5'h01 : su_q;
			al_q <= ale ? al_q + 5'h01 : 5'h00;
			hd_q <= !st ? 5'h00 : ad_oe ? hd_q + 5'h01 : hd_q;
			ws_q <= ale ? 1'b0 : !wr_n ? 1'b1 : ws_q;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	property p_width; $rose(st) |-> lo_q == tim_q[5:2] + 5'h01; endproperty
	a_width: assert property (p_width) else $error("strobe width wrong");
	property p_setup; $fell(st) |-> su_q == cfg_q[1:0] + tim_q[7:6] + 5'h01; endproperty
	a_setup: assert property (p_setup) else $error("setup wrong");
	property p_latch; $fell(ale) |-> al_q == cfg_q[1:0] + 5'h01; endproperty
	a_latch: assert property (p_latch) else $error("latch width wrong");
	property p_hold; $fell(ad_oe) && ws_q |-> hd_q == tim_q[1:0]; endproperty
	a_hold: assert property (p_hold) else $error("hold wrong");
	property p_wdrv; !wr_n |-> ad_oe; endproperty
	a_wdrv: assert property (p_wdrv) else $error("write data not driven");
	property p_wstab; !wr_n ##1 !wr_n |-> $stable(ad_out); endproperty
	a_wstab: assert property (p_wstab) else $error("write data moved");
	property p_excl; rd_n || wr_n; endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	property p_order; $rose(ale) |-> st && ad_oe; endproperty
	a_order: assert property (p_order) else $error("latch phase wrong");
	c_rd: cover property ($rose(rd_n));
	c_wr: cover property ($rose(wr_n));
	c_ale: cover property ($fell(ale) && al_q == 5'h04);
endmodule : emt_chk
bind emt_ctrl emt_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_page(sfr_page),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .ad_oe(ad_oe),
	.ad_out(ad_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
`default_nettype wire

// ### emt_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module emt_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	emt_stream_if.snk wr_side,
	emt_stream_if.src rd_side
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
	logic [AW:0] cnt_q, cnt_d;
	logic nfull_q, nfull_d;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(D - 1)) ? '0 : p + AW'(1);
	endfunction : bump

	assign push = wr_side.valid && nfull_q;
	assign pop = rd_side.valid && rd_side.ready;
	assign wr_side.ready = nfull_q;
	assign rd_side.valid = (cnt_q != '0);
	assign rd_side.data = mem_q[rptr_q];

	always_comb begin
		wptr_d = push ? bump(wptr_q) : wptr_q;
		rptr_d = pop ? bump(rptr_q) : rptr_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		nfull_d = (cnt_d != FULL_CNT);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
			nfull_q <= 1'b1;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q <= cnt_d;
			nfull_q <= nfull_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wptr_q] <= wr_side.data;
		end
	end
endmodule : emt_fifo
`default_nettype wire

// ### emt_mem.sv
`timescale 1ns/100ps
`default_nettype none
module emt_mem (
	input wire logic clk_sys,
	input wire logic slow,
	input wire logic [7:0] addr_hi,
	input wire logic [7:0] ad_out,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic [7:0] ad_in,
	output logic [15:0] lat_q
);
	logic [7:0] mem [0:65535];
	logic [7:0] old_q;
	logic rd_q;
	always_ff @(posedge clk_sys) begin
		rd_q <= rd_n;
		if (ale)
			lat_q <= {addr_hi, ad_out};
		if (!wr_n)
			mem[lat_q] <= ad_out;
		if (!rd_n)
			old_q <= ad_in;
	end
	// Slow answer skips the first strobe cycle; released bus shows inverted last value
	assign ad_in = (!rd_n && !(slow && rd_q)) ? mem[lat_q] : ~old_q;
endmodule : emt_mem
`default_nettype wire

// ### emt_pkg.sv
package emt_pkg;
	// Register file address map and page
	localparam logic [7:0] SFR_PAGE_EMT = 8'h00;
	localparam logic [7:0] ADDR_PAGE_CTL = 8'haa;
	localparam logic [7:0] ADDR_BUS_CFG = 8'hab;
	localparam logic [7:0] ADDR_TIMING = 8'haf;
	// Reset values
	localparam logic [7:0] RST_PAGE_CTL = 8'h00;
	localparam logic [7:0] RST_BUS_CFG = 8'h03;
	localparam logic [7:0] RST_TIMING = 8'hff;
	// Field layout of the timing register
	localparam int SETUP_LSB = 6;
	localparam int WIDTH_LSB = 2;
	localparam int HOLD_LSB = 0;
	// Field layout of the configuration register
	localparam int MODE_LSB = 2;
	localparam int LATCH_LSB = 0;
	// Writable bits
	localparam logic [7:0] PAGE_MASK = 8'h1f;
	localparam logic [7:0] CFG_MASK = 8'h0f;
	// Interface modes
	typedef enum logic [1:0] {
		MODE_INTERNAL = 2'h0,
		MODE_SPLIT_NOBANK = 2'h1,
		MODE_SPLIT_BANK = 2'h2,
		MODE_EXTERNAL = 2'h3
	} emt_mode_t;
	// Bus cycle phases
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ALE_HIGH = 6'h02,
		ST_ALE_LOW = 6'h04,
		ST_SETUP = 6'h08,
		ST_STROBE = 6'h10,
		ST_HOLD = 6'h20
	} emt_state_t;
	// Queued request: write, wide address, address, write data
	localparam int REQ_W = 26;
	localparam int FIFO_DEPTH = 8;
endpackage : emt_pkg

// ### emt_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface emt_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : emt_stream_if
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] sfr_page = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, req_wdata = 8'h00;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_wide = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic slow = 1'b0, full_seen = 1'b0;
	logic [7:0] sfr_rdata, rsp_rdata, addr_hi, ad_out, ad_in;
	logic req_ready, rsp_valid, ad_oe, ale, rd_n, wr_n;
	logic [15:0] lat_q;
	logic [7:0] tims [4] = '{8'h00, 8'h47, 8'h9a, 8'hff};
	int bad_count = 0, tests_run = 0, rsp_cnt = 0, ale_cnt = 0;
	always #4 clk_sys = ~clk_sys;
	emt_ctrl uut (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_page(sfr_page),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_wide(req_wide), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.addr_hi(addr_hi), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in), .ale(ale),
		.rd_n(rd_n), .wr_n(wr_n));
	emt_mem u_mem (.clk_sys(clk_sys), .slow(slow), .addr_hi(addr_hi), .ad_out(ad_out),
		.ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in), .lat_q(lat_q));
	always @(posedge ale)
		ale_cnt++;
	always @(negedge clk_sys) begin
		if (rsp_valid === 1'b1)
			rsp_cnt++;
		if (req_ready === 1'b0)
			full_seen <= 1'b1;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
		sfr_page <= p;
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
		sfr_page <= p;
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		@(posedge clk_sys);
		chk(sfr_rdata, e);
	endtask : rd
	// Holds the request until the edge that takes it
	task automatic push(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d);
		req_valid <= 1'b1;
		req_write <= w;
		req_wide <= wd;
		req_addr <= a;
		req_wdata <= d;
		@(negedge clk_sys);
		while (req_ready !== 1'b1)
			@(negedge clk_sys);
		@(posedge clk_sys);
	endtask : push
	task automatic xfer(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = rsp_cnt;
		push(w, wd, a, d);
		req_valid <= 1'b0;
		for (int i = 0; i < 400 && rsp_cnt == n; i++)
			@(posedge clk_sys);
		chk(16'(rsp_cnt - n), 16'h0001);
	endtask : xfer
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		bad_count++;
		stop_test;
	end
	initial begin
		int n;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		rd(8'h00, 8'haf, 8'hff);
		rd(8'h00, 8'hab, 8'h03);
		rd(8'h00, 8'hac, 8'h00);
		wr(8'h0f, 8'haf, 8'h00);
		rd(8'h0f, 8'haf, 8'h00);
		rd(8'h00, 8'haf, 8'hff);
		wr(8'h00, 8'haa, 8'hff);
		rd(8'h00, 8'haa, 8'h1f);
		wr(8'h00, 8'hab, 8'h00);
		xfer(1'b0, 1'b1, 16'h1234, 8'h00);
		chk(rsp_rdata, 8'h00);
		chk(16'(ale_cnt), 16'h0000);
		foreach (tims[i]) begin
			wr(8'h00, 8'haf, tims[i]);
			wr(8'h00, 8'hab, 8'h0c | 8'(i));
			slow <= (i % 2) == 1;
			xfer(1'b1, 1'b1, {8'h40 + 8'(i), 8'h21}, 8'ha0 + 8'(i));
			chk(addr_hi, 8'h40 + 8'(i));
			xfer(1'b0, 1'b1, {8'h40 + 8'(i), 8'h21}, 8'h00);
			chk(rsp_rdata, 8'ha0 + 8'(i));
			chk(lat_q, {8'h40 + 8'(i), 8'h21});
		end
		wr(8'h00, 8'haa, 8'h13);
		for (int m = 1; m < 4; m++) begin
			wr(8'h00, 8'hab, 8'(m << 2));
			xfer(1'b1, 1'b1, 16'h7700, 8'h00);
			xfer(1'b1, 1'b0, 16'hff55, 8'h50 + 8'(m));
			chk(addr_hi, m == 2 ? 8'h13 : 8'h77);
			xfer(1'b0, 1'b0, 16'h0055, 8'h00);
			chk(rsp_rdata, 8'h50 + 8'(m));
		end
		wr(8'h00, 8'hab, 8'h0f);
		n = rsp_cnt;
		for (int k = 0; k < 12; k++)
			push(1'b1, 1'b1, 16'h3000 + 16'(k), 8'(k));
		req_valid <= 1'b0;
		for (int k = 0; k < 1000 && rsp_cnt < n + 12; k++)
			@(posedge clk_sys);
		chk(full_seen, 1'b1);
		chk(16'(rsp_cnt - n), 16'h000c);
		xfer(1'b0, 1'b1, 16'h300b, 8'h00);
		chk(rsp_rdata, 8'h0b);
		stop_test;
	end
endmodule : testbench
`default_nettype wire
